// [rtl/scg_pkg.sv]
// Constants, types and helper functions shared by the sleep-mode clock gating block.
// Assumes register offsets are byte offsets from the system control base address.
`default_nettype none

package scg_pkg;

  // System control base address; the register port carries only the offset from it.
  localparam logic [31:0] SYS_CTRL_BASE      = 32'h400FE000;

  // Register offsets on the register port.
  localparam logic [11:0] SLEEP_GATE_OFS     = 12'h110;
  localparam logic [11:0] INT_STATUS_OFS     = 12'h1F0;
  localparam logic [11:0] INT_ENABLE_OFS     = 12'h1F4;
  localparam logic [11:0] INT_CLEAR_OFS      = 12'h1F8;

  // Field positions inside a gating word.
  localparam int unsigned PWM_BIT            = 20;
  localparam int unsigned ADC_BIT            = 16;
  localparam int unsigned HIB_BIT            = 6;
  localparam int unsigned WDT_BIT            = 3;
  localparam int unsigned RATE_LSB           = 8;
  localparam int unsigned RATE_MSB           = 9;

  // Reset value and the mask of bits that software may change.
  localparam logic [31:0] SLEEP_GATE_RESET   = 32'h00000040;
  localparam logic [31:0] SLEEP_GATE_WMASK   = 32'h00110348;

  // Converter sample rate codes.
  localparam logic [1:0]  RATE_125K          = 2'h0;
  localparam logic [1:0]  RATE_250K          = 2'h1;
  localparam logic [1:0]  RATE_500K          = 2'h2;

  // Unit indexes, shared by the enable vector and the fault status bits.
  localparam int unsigned UNIT_COUNT         = 4;
  localparam logic [1:0]  UNIT_WDT           = 2'h0;
  localparam logic [1:0]  UNIT_HIB           = 2'h1;
  localparam logic [1:0]  UNIT_ADC           = 2'h2;
  localparam logic [1:0]  UNIT_PWM           = 2'h3;

  // Power state of the system as seen by the gating logic.
  typedef enum logic [1:0] {
    SCG_RUN,
    SCG_SLEEP,
    SCG_DEEP
  } scg_mode_t;

  // Limits a sample rate code to the highest code the part supports.
  function automatic logic [1:0] scg_rate_clamp(input logic [1:0] code,
                                                input logic [1:0] maxCode);
    scg_rate_clamp = (code > maxCode) ? maxCode : code;
  endfunction

  // Gathers the unit enable bits of a gating word into a vector indexed by unit.
  function automatic logic [UNIT_COUNT-1:0] scg_unit_enables(input logic [31:0] word);
    logic [UNIT_COUNT-1:0] en;
    en = '0;
    en[UNIT_WDT] = word[WDT_BIT];
    en[UNIT_HIB] = word[HIB_BIT];
    en[UNIT_ADC] = word[ADC_BIT];
    en[UNIT_PWM] = word[PWM_BIT];
    scg_unit_enables = en;
  endfunction

  // Enable vector that the reset value of the gating word implies.
  localparam logic [UNIT_COUNT-1:0] CLKEN_RESET = scg_unit_enables(SLEEP_GATE_RESET);

endpackage

`default_nettype wire

// [rtl/scg_gate_select.sv]
// Chooses the gating word that applies in the current power state.
// Assumes the run and deep-sleep words arrive as steady levels from sibling registers.
`default_nettype none

module scg_gate_select (
  input  wire logic              autoGateSelect,
  input  wire scg_pkg::scg_mode_t mode,
  input  wire logic [31:0]       runWord,
  input  wire logic [31:0]       sleepWord,
  input  wire logic [31:0]       deepWord,
  output var  logic [31:0]       activeWord
);

  // Without automatic gating the run word stays in force in every power state.
  always_comb begin
    activeWord = runWord;
    if (autoGateSelect) begin
      case (mode)
        scg_pkg::SCG_SLEEP: activeWord = sleepWord;
        scg_pkg::SCG_DEEP:  activeWord = deepWord;
        default:            activeWord = runWord;
      endcase
    end
  end

endmodule

`default_nettype wire

// [rtl/scg_sleep_gate.sv]
// Sleep-mode clock gating register 0 with its clock enables and bus fault check.
// Assumes a plain register port, synchronous inputs and one 20 MHz clock.
//
// Overview of operation
// - A set gating bit clocks its unit and a clear bit leaves it unclocked.
// - Any access to a unit whose clock enable is clear returns a bus fault.
// - The register resets to 0x00000040, with only the hibernation bit set.
// - Bit 20 is the read-write pulse-width modulator enable, reset zero.
// - Bit 16 is the read-write converter module 0 enable, reset zero.
// - Bit 6 is the read-write hibernation enable, reset one.
// - Bit 3 is the read-write watchdog enable, reset zero.
// - Bits 9:8 choose 125K, 250K or 500K converter samples per second, reset zero.
// - A written sample rate code never exceeds the highest rate of the part.
// - Reserved bits read zero and ignore writes.
// - This register applies only while the system sleeps.
// - The sleep register applies only when automatic gating is selected.
// - The register answers at offset 0x110 from the system control base.
//
// Our own choice: the plain strobed port.
`default_nettype none

module scg_sleep_gate #(
  parameter int unsigned ADDR_W        = 12,
  parameter logic [1:0]  MAX_RATE_CODE = scg_pkg::RATE_500K
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdData,
  input  wire logic              autoGateSelect,
  input  wire logic              sleepActive,
  input  wire logic              deepSleepActive,
  input  wire logic [31:0]       runGateWord,
  input  wire logic [31:0]       deepGateWord,
  input  wire logic              periphReq,
  input  wire logic [1:0]        periphUnit,
  output logic                   busFault,
  output logic                   pwmClkEn,
  output logic                   adcClkEn,
  output logic                   hibClkEn,
  output logic                   wdtClkEn,
  output logic      [1:0]        sampleRate,
  output logic                   irq
);

  localparam int unsigned UN = scg_pkg::UNIT_COUNT;

  // All state of the block in one record.
  typedef struct packed {
    logic [31:0]        gate;
    logic [31:0]        rdData;
    scg_pkg::scg_mode_t mode;
    logic [UN-1:0]      clkEn;
    logic [1:0]         rate;
    logic [UN-1:0]      status;
    logic [UN-1:0]      enable;
    logic               fault;
    logic               irq;
  } scg_state_t;

  scg_state_t  state_ff;
  scg_state_t  nxt_state;
  logic [31:0] activeWord;
  logic [31:0] wrWord;
  logic [31:0] activeWordSafe;

  // Address decode of the register port.
  logic hitGate;
  logic hitStatus;
  logic hitEnable;
  logic hitClear;

  // Offsets are compared at the port width so a narrow port still decodes cleanly.
  always_comb begin
    hitGate   = 1'b0;
    hitStatus = 1'b0;
    hitEnable = 1'b0;
    hitClear  = 1'b0;
    if (regAddr == ADDR_W'(scg_pkg::SLEEP_GATE_OFS)) begin
      hitGate = 1'b1;
    end else if (regAddr == ADDR_W'(scg_pkg::INT_STATUS_OFS)) begin
      hitStatus = 1'b1;
    end else if (regAddr == ADDR_W'(scg_pkg::INT_ENABLE_OFS)) begin
      hitEnable = 1'b1;
    end else if (regAddr == ADDR_W'(scg_pkg::INT_CLEAR_OFS)) begin
      hitClear = 1'b1;
    end
  end

  // Write value for the gating word: only writable bits change, reserved bits stay zero.
  always_comb begin
    wrWord = regWrData & scg_pkg::SLEEP_GATE_WMASK;
    wrWord[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB] =
      scg_pkg::scg_rate_clamp(regWrData[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB],
                              MAX_RATE_CODE);
  end

  // Picks the word in force for the present power state.
  scg_gate_select u_select (
    .autoGateSelect (autoGateSelect),
    .mode           (state_ff.mode),
    .runWord        (runGateWord),
    .sleepWord      (state_ff.gate),
    .deepWord       (deepGateWord),
    .activeWord     (activeWord)
  );

  // The sibling words may carry higher rate codes, so the clamp is applied again here.
  always_comb begin
    activeWordSafe = activeWord;
    activeWordSafe[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB] =
      scg_pkg::scg_rate_clamp(activeWord[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB],
                              MAX_RATE_CODE);
  end

  // Next-state logic for the whole block.
  always_comb begin
    logic [UN-1:0] setBits;
    logic [UN-1:0] clrBits;
    setBits   = '0;
    clrBits   = '0;
    nxt_state = state_ff;

    // Power state follows the system; deep sleep wins when both are reported.
    case (state_ff.mode)
      scg_pkg::SCG_RUN: begin
        if (deepSleepActive) begin
          nxt_state.mode = scg_pkg::SCG_DEEP;
        end else if (sleepActive) begin
          nxt_state.mode = scg_pkg::SCG_SLEEP;
        end
      end
      scg_pkg::SCG_SLEEP: begin
        if (deepSleepActive) begin
          nxt_state.mode = scg_pkg::SCG_DEEP;
        end else if (!sleepActive) begin
          nxt_state.mode = scg_pkg::SCG_RUN;
        end
      end
      scg_pkg::SCG_DEEP: begin
        if (!deepSleepActive) begin
          nxt_state.mode = sleepActive ? scg_pkg::SCG_SLEEP : scg_pkg::SCG_RUN;
        end
      end
      default: begin
        nxt_state.mode = scg_pkg::SCG_RUN;
      end
    endcase

    // Register writes; the status register is read-only and ignores writes.
    if (regWr) begin
      if (hitGate) begin
        nxt_state.gate = wrWord;
      end else if (hitEnable) begin
        nxt_state.enable = regWrData[UN-1:0];
      end else if (hitClear) begin
        clrBits = regWrData[UN-1:0];
      end
    end

    // Clock enables and rate follow the word in force.
    nxt_state.clkEn = scg_pkg::scg_unit_enables(activeWordSafe);
    nxt_state.rate  = activeWordSafe[scg_pkg::RATE_MSB:scg_pkg::RATE_LSB];

    // An access to an unclocked unit is refused with a one-cycle fault.
    nxt_state.fault = 1'b0;
    if (periphReq && !state_ff.clkEn[periphUnit]) begin
      nxt_state.fault        = 1'b1;
      setBits[periphUnit]    = 1'b1;
    end

    // A fault in the same cycle as its clear keeps the bit set.
    nxt_state.status = (state_ff.status & ~clrBits) | setBits;
    nxt_state.irq    = |(nxt_state.status & nxt_state.enable);

    // Read data stands in the cycle after the read strobe only.
    nxt_state.rdData = '0;
    if (regRd) begin
      if (hitGate) begin
        nxt_state.rdData = state_ff.gate;
      end else if (hitStatus) begin
        nxt_state.rdData = {{(32-UN){1'b0}}, state_ff.status};
      end else if (hitEnable) begin
        nxt_state.rdData = {{(32-UN){1'b0}}, state_ff.enable};
      end
    end
  end

  // State register; the reset record holds constants only.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.gate   <= scg_pkg::SLEEP_GATE_RESET;
      state_ff.rdData <= '0;
      state_ff.mode   <= scg_pkg::SCG_RUN;
      state_ff.clkEn  <= scg_pkg::CLKEN_RESET;
      state_ff.rate   <= scg_pkg::RATE_125K;
      state_ff.status <= '0;
      state_ff.enable <= '0;
      state_ff.fault  <= 1'b0;
      state_ff.irq    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register.
  assign regRdData  = state_ff.rdData;
  assign busFault   = state_ff.fault;
  assign pwmClkEn   = state_ff.clkEn[scg_pkg::UNIT_PWM];
  assign adcClkEn   = state_ff.clkEn[scg_pkg::UNIT_ADC];
  assign hibClkEn   = state_ff.clkEn[scg_pkg::UNIT_HIB];
  assign wdtClkEn   = state_ff.clkEn[scg_pkg::UNIT_WDT];
  assign sampleRate = state_ff.rate;
  assign irq        = state_ff.irq;

endmodule

`default_nettype wire

// [testbench/scg_sleep_gate_chk.sv]
// Port checker for the sleep-mode clock gating block.
// Assumes one clock domain and the block's asynchronous active-low reset.
`default_nettype none

module scg_sleep_gate_chk #(
  parameter int unsigned ADDR_W        = 12,
  parameter logic [1:0]  MAX_RATE_CODE = 2'h2
) (
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdData,
  input wire logic              autoGateSelect,
  input wire logic              sleepActive,
  input wire logic              deepSleepActive,
  input wire logic [31:0]       runGateWord,
  input wire logic [31:0]       deepGateWord,
  input wire logic              periphReq,
  input wire logic [1:0]        periphUnit,
  input wire logic              busFault,
  input wire logic              pwmClkEn,
  input wire logic              adcClkEn,
  input wire logic              hibClkEn,
  input wire logic              wdtClkEn,
  input wire logic [1:0]        sampleRate,
  input wire logic              irq
);
  // Enables by unit index and the condition under which this register governs.
  wire logic [3:0] en  = {pwmClkEn, adcClkEn, hibClkEn, wdtClkEn};
  wire logic       slp = autoGateSelect && sleepActive && !deepSleepActive;
  logic [31:0]     lastWr_ff;

  // Keeps the last written word for the sleep word check.
  always_ff @(posedge clock) begin
    if (regWr) lastWr_ff <= regWrData;
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_reset_vals: assert property ($rose(rst_n) |-> en == 4'h2 && sampleRate == 2'h0)
    else $error("enables not at reset values");
  a_rate_max: assert property (sampleRate <= MAX_RATE_CODE)
    else $error("sample rate above the maximum");
  a_fault_set: assert property (periphReq && !en[periphUnit] |=> busFault)
    else $error("missing bus fault");
  a_fault_cause: assert property (
    busFault |-> $past(periphReq) && !$past(en[periphUnit]))
    else $error("bus fault without cause");
  a_read_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_sleep_word: assert property (
    regWr && regAddr == 12'h110 && slp && $past(slp) ##1
    (slp && !regWr)[*2] |-> en == {lastWr_ff[20], lastWr_ff[16], lastWr_ff[6], lastWr_ff[3]}
    && sampleRate == ((lastWr_ff[9:8] > MAX_RATE_CODE) ? MAX_RATE_CODE : lastWr_ff[9:8]))
    else $error("sleep word not applied");
  a_run_word: assert property ((!autoGateSelect && $stable(runGateWord))[*3] |->
    en == {runGateWord[20], runGateWord[16], runGateWord[6], runGateWord[3]})
    else $error("run word not applied");
  // The power state restarts in run after reset, so the window must begin out of reset.
  a_deep_word: assert property (
    ($past(rst_n) && autoGateSelect && deepSleepActive && $stable(deepGateWord))[*3]
    |-> en == {deepGateWord[20], deepGateWord[16], deepGateWord[6], deepGateWord[3]})
    else $error("deep word not applied");

  // Main scenarios reached by the bench.
  c_fault: cover property (busFault);
  c_irq: cover property (irq);
  c_fast_rate: cover property (slp && sampleRate == 2'h2);
endmodule

bind scg_sleep_gate scg_sleep_gate_chk #(.ADDR_W(ADDR_W), .MAX_RATE_CODE(MAX_RATE_CODE)) chk_inst (
  .clock, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .autoGateSelect,
  .sleepActive, .deepSleepActive, .runGateWord, .deepGateWord, .periphReq, .periphUnit,
  .busFault, .pwmClkEn, .adcClkEn, .hibClkEn, .wdtClkEn, .sampleRate, .irq);

`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the sleep-mode clock gating block.
// Assumes the port checker is bound to the block from its own file.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] regAddr = 12'h0;
  logic [31:0] regWrData = 32'h0, runGateWord = 32'h0, deepGateWord = 32'h0, regRdData, d;
  logic        regWr = 1'b0, regRd = 1'b0, autoGateSelect = 1'b0, sleepActive = 1'b0;
  logic        deepSleepActive = 1'b0, periphReq = 1'b0, busFault, irq;
  logic        pwmClkEn, adcClkEn, hibClkEn, wdtClkEn;
  logic [1:0]  periphUnit = 2'h0, sampleRate;
  logic [3:0]  e;
  int          fails = 0;
  int          cmp_count = 0;

  // Clock of 50 ns period.
  always #25 clock = ~clock;

  scg_sleep_gate scg_sleep_gate_inst (
    .clock, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .autoGateSelect,
    .sleepActive, .deepSleepActive, .runGateWord, .deepGateWord, .periphReq, .periphUnit,
    .busFault, .pwmClkEn, .adcClkEn, .hibClkEn, .wdtClkEn, .sampleRate, .irq);

  // Expected register readback: writable bits only, rate code limited to 2.
  function automatic logic [31:0] expReg(input logic [31:0] v);
    logic [31:0] m;
    m = v & 32'h00110348;
    if (m[9:8] == 2'h3) m[9:8] = 2'h2;
    return m;
  endfunction

  // Compares one result and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Register write of one cycle.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  // Register read, data compared in the cycle after the strobe.
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask

  // Lets the enables settle, then compares them with a gating word.
  task automatic chkEn(input logic [31:0] w);
    repeat (3) @(posedge clock);
    #1 chk({28'h0, pwmClkEn, adcClkEn, hibClkEn, wdtClkEn}, {28'h0, w[20], w[16], w[6], w[3]});
  endtask

  // Peripheral access attempt, fault pulse compared in the next cycle.
  task automatic fl(input logic [1:0] u, input logic f);
    @(posedge clock);
    periphReq <= 1'b1;
    periphUnit <= u;
    @(posedge clock);
    periphReq <= 1'b0;
    #1 chk({31'h0, busFault}, {31'h0, f});
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    $display("[FAIL] %0t run too long", $time);
    wrap_up();
  end

  // Main sequence: reset, register map, gating words, faults and interrupts.
  initial begin
    void'($urandom(32'h7C43));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rdc(12'h110, 32'h00000040);
    @(posedge clock);
    autoGateSelect <= 1'b1;
    sleepActive <= 1'b1;
    chkEn(32'h00000040);
    wr(12'h110, 32'hFFFFFFFF);
    rdc(12'h110, 32'h00110248);
    chkEn(32'hFFFFFFFF);
    for (int r = 0; r < 4; r++) begin
      wr(12'h110, {22'h0, r[1:0], 8'h0});
      chkEn(32'h0);
      chk({30'h0, sampleRate}, (r == 3) ? 32'h2 : 32'(r));
    end
    wr(12'h1F4, 32'h0000000F);
    rdc(12'h1F4, 32'h0000000F);
    repeat (12) begin
      d = $urandom;
      wr(12'h110, d);
      rdc(12'h110, expReg(d));
      chkEn(d);
      e = {d[20], d[16], d[6], d[3]};
      for (int u = 0; u < 4; u++) fl(u[1:0], ~e[u]);
      rdc(12'h1F0, {28'h0, ~e});
      chk({31'h0, irq}, {31'h0, |(~e)});
      wr(12'h1F8, 32'h0000000F);
      rdc(12'h1F0, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    wr(12'h110, expReg(d) | 32'h00000008);
    rdc(12'h110, expReg(d) | 32'h00000008);
    wr(12'h1F4, 32'h0);
    wr(12'h110, 32'h0);
    fl(2'h3, 1'b1);
    rdc(12'h1F0, 32'h00000008);
    chk({31'h0, irq}, 32'h0);
    rdc(12'h1F8, 32'h0);
    wr(12'h114, 32'hFFFFFFFF);
    rdc(12'h114, 32'h0);
    rdc(12'h110, 32'h0);
    d = $urandom;
    @(posedge clock);
    autoGateSelect <= 1'b0;
    runGateWord <= d;
    chkEn(d);
    d = $urandom;
    @(posedge clock);
    autoGateSelect <= 1'b1;
    deepSleepActive <= 1'b1;
    deepGateWord <= d;
    chkEn(d);
    @(posedge clock);
    deepSleepActive <= 1'b0;
    chkEn(32'h0);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdc(12'h110, 32'h00000040);
    wrap_up();
  end
endmodule

`default_nettype wire
